// ==== tb/apm_mem_model.sv ====
`timescale 1ns/1ps

// Far side of the shared pins: an external memory plus the board wiring.
module apm_mem_model
(
  input wire logic clk_i,
  input wire logic bus_active_i,
  input wire logic [15:0] pin_drv_i,
  input wire logic [15:0] pin_oe_i,
  input wire logic [15:0] pin_pullup_i,
  output logic [15:0] pin_level_o,
  output logic [15:0] last_addr_o
);
  logic [15:0] stray = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // A floating pin with no pull-up toggles, so it never reads as a value.
  always_ff @(posedge clk_i)
  begin
    stray <= ~stray;
  end

  assign pin_level_o = (pin_oe_i & pin_drv_i)
    | (~pin_oe_i & pin_pullup_i) | (~pin_oe_i & ~pin_pullup_i & stray);

  ////////////////////////////////////////////////////////////////////////
  // The memory takes an address only while every line is driven.
  always_ff @(posedge clk_i)
  begin
    if (bus_active_i && (&pin_oe_i))
    begin
      last_addr_o <= pin_drv_i;
    end
  end
endmodule

// ==== tb/test_apm_pin_mux.sv ====
`timescale 1ns/1ps

module test_apm_pin_mux;
  import apm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_ack_o;
  logic clk_o;
  logic clk_oe;
  logic ctrl_oe;
  logic [1:0] ctrl_o;
  logic [7:0] src = 8'h00;
  logic [15:0] emi_addr = 16'h0000;
  logic emi_act = 1'b0;
  logic [1:0] emi_ctrl = 2'b10;
  logic [3:0] lanes = 4'hF;
  logic [15:0] pin_i;
  logic [15:0] pin_o;
  logic [15:0] pin_oe;
  logic [15:0] pin_pu;
  logic [15:0] seen;
  logic [15:0] rv [0:6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'hFFFF, 16'hFFFF};
  int n_fail = 0;
  int comparisons = 0;

  always #20 clk_i = ~clk_i;

  apm_pin_mux u_apm_pin_mux
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .master_system_clock_i(src[1]),
    .peripheral_bus_clock_i(src[2]), .osc_clock_i(src[3]),
    .prescaler_clock_i(src[4]), .postscaler_clock_i(src[5]),
    .test_clock_i(src[7:6]), .buffered_clock_out_pin_o(clk_o),
    .buffered_clock_out_pin_oe_o(clk_oe), .emi_addr_i(emi_addr),
    .emi_bus_active_i(emi_act), .emi_ctrl_i(emi_ctrl), .emi_ctrl_o(ctrl_o),
    .emi_ctrl_oe_o(ctrl_oe), .addr_pin_i(pin_i), .addr_pin_o(pin_o),
    .addr_pin_oe_o(pin_oe), .addr_pin_pullup_o(pin_pu)
  );

  apm_mem_model u_apm_mem_model
  (
    .clk_i(clk_i), .bus_active_i(emi_act), .pin_drv_i(pin_o),
    .pin_oe_i(pin_oe), .pin_pullup_i(pin_pu), .pin_level_o(pin_i),
    .last_addr_o(seen)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // The master never assumes a latency; only the bound cuts a hang.
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= lanes;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      chk(32'h0000_0000, 32'h0000_0001);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    test_done();
  end

  initial
  begin
    settle();
    chk(pin_oe, 32'h0000_0000);
    chk(pin_pu, 32'h0000_FFFF);
    chk(clk_oe, 32'h0000_0000);
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b0, 8'(i * 4), 32'h0000_0000);
      chk(q, rv[i]);
    end
    @(posedge clk_i);
    emi_addr <= 16'hA5C3;
    emi_act <= 1'b1;
    settle();
    chk(pin_o, 32'h0000_A5C3);
    chk(pin_oe, 32'h0000_FFFF);
    chk(ctrl_o, 32'h0000_0002);
    chk(seen, 32'h0000_A5C3);
    @(posedge clk_i);
    emi_act <= 1'b0;
    emi_ctrl <= 2'b01;
    settle();
    chk({ctrl_oe, pin_oe}, 32'h0000_0000);
    chk(ctrl_o, 32'h0000_0001);
    wb(1'b1, 8'h04, 32'h0000_0001);
    settle();
    chk({ctrl_oe, pin_oe}, 32'h0001_FFFF);
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b1, 8'h00, 32'(k));
      @(posedge clk_i);
      src <= 8'h01 << k;
      settle();
      chk({clk_oe, clk_o}, (k == 0) ? 32'h0 : 32'h3);
      @(posedge clk_i);
      src <= 8'h00;
      settle();
      chk({clk_oe, clk_o}, (k == 0) ? 32'h0 : 32'h2);
    end
    wb(1'b1, 8'h08, 32'h0000_FFFF);
    wb(1'b1, 8'h0C, 32'h0000_5555);
    wb(1'b1, 8'h10, 32'h0000_3333);
    settle();
    chk(pin_oe, 32'h0000_5555);
    chk(pin_o & 16'h5555, 32'h0000_1111);
    wb(1'b0, 8'h1C, 32'h0000_0000);
    chk(q, 32'h0000_BBBB);
    wb(1'b1, 8'h1C, 32'h0000_0000);
    wb(1'b0, 8'h1C, 32'h0000_0000);
    chk(q, 32'h0000_BBBB);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // Only lane 1 is enabled, so the low direction byte must survive.
    lanes = 4'h2;
    wb(1'b1, 8'h0C, 32'h0000_00FF);
    lanes = 4'hF;
    settle();
    chk(pin_oe, 32'h0000_0055);
    wb(1'b1, 8'h14, 32'h0000_FEFE);
    wb(1'b1, 8'h18, 32'h0000_FFFB);
    settle();
    chk(pin_pu, 32'h0000_FEBE);
    wb(1'b0, 8'h18, 32'h0000_0000);
    chk(q, 32'h0000_FFFB);
    test_done();
  end
endmodule

// ==== verilog/apm_clk_out.sv ====
`timescale 1ns/1ps
`include "apm_params.svh"

module apm_clk_out
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire apm_pkg::apm_clk_sel_t sel_i,
  input wire apm_pkg::apm_clk_src_t src_i,
  output logic clk_out_o,
  output logic clk_out_oe_o
);
  import apm_pkg::*;

  // Sources are sampled like any other input, so a source faster than
  // half the block clock cannot be forwarded faithfully.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_out_o <= 1'b0;
      clk_out_oe_o <= 1'b0;
    end
    else
    begin
      clk_out_o <= (sel_i != APM_CLK_OFF) && src_i[sel_i];
      clk_out_oe_o <= (sel_i != APM_CLK_OFF);
    end
  end

  AST_CLK_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i != APM_CLK_OFF |=> clk_out_oe_o && clk_out_o == $past(src_i[sel_i]))
    else $error("Clock out does not follow the selected source.");

  AST_CLK_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i == APM_CLK_OFF |=> !clk_out_oe_o && !clk_out_o)
    else $error("Clock out driven while disabled.");

  AST_CLK_TEST: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i inside {APM_CLK_TEST0, APM_CLK_TEST1} |=> clk_out_oe_o)
    else $error("Test source not driven on clock out.");

endmodule

// ==== verilog/apm_params.svh ====
`ifndef APM_PARAMS_SVH
`define APM_PARAMS_SVH

// Register byte offsets on the register bus.
`define APM_OFS_CLK_SEL 8'h00
`define APM_OFS_BUS_CTRL 8'h04
`define APM_OFS_PORT_FUNC 8'h08
`define APM_OFS_PORT_DIR 8'h0C
`define APM_OFS_PORT_OUT 8'h10
`define APM_OFS_PA_PULLUP 8'h14
`define APM_OFS_PE_PULLUP 8'h18
`define APM_OFS_PIN_IN 8'h1C

// Field positions and reset values.
`define APM_BUS_KEEP_BIT 0
`define APM_RST_CLK_SEL 3'h0
`define APM_RST_BUS_CTRL 1'b0
`define APM_RST_PORT_FUNC 16'h0000
`define APM_RST_PORT_DIR 16'h0000
`define APM_RST_PORT_OUT 16'h0000
`define APM_RST_PULLUP 16'hFFFF

// Address line groups and the port bits that they share pins with.
`define APM_GRP0_END 6
`define APM_GRP1_END 8
`define APM_GRP0_PA_BASE 8
`define APM_GRP1_PE_BASE 2
`define APM_GRP2_PA_BASE 0

`endif

// ==== verilog/apm_pin_mux.sv ====
`timescale 1ns/1ps
`include "apm_params.svh"

// What this block does
// - The clock-out pin buffers the clock that the source select picks.
// - The source select also offers internal test signals as sources.
// - Address pins carry memory address lines, shared with port bits.
// - An idle bus floats address and control pins unless kept driven.
// - After reset every shared pin takes its address function.
// - In port function each pin has its own direction.
// - Clearing a port pull-up bit turns off its shared pin's pull-up: PA bit n+8 for pin n<6, PE bits 2-3 for pins 6-7, PA bit n-8 for pin n>=8.
module apm_pin_mux
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_system_clock_i,
  input wire logic peripheral_bus_clock_i,
  input wire logic osc_clock_i,
  input wire logic prescaler_clock_i,
  input wire logic postscaler_clock_i,
  input wire logic [1:0] test_clock_i,
  output logic buffered_clock_out_pin_o,
  output logic buffered_clock_out_pin_oe_o,
  input wire logic [15:0] emi_addr_i,
  input wire logic emi_bus_active_i,
  input wire logic [1:0] emi_ctrl_i,
  output logic [1:0] emi_ctrl_o,
  output logic emi_ctrl_oe_o,
  input wire logic [15:0] addr_pin_i,
  output logic [15:0] addr_pin_o,
  output logic [15:0] addr_pin_oe_o,
  output logic [15:0] addr_pin_pullup_o
);
  import apm_pkg::*;

  apm_clk_sel_t clk_sel;
  logic bus_keep_driven_bit;
  logic [15:0] port_func;
  logic [15:0] port_dir;
  logic [15:0] port_out;
  logic [15:0] port_a_pullup_enable;
  logic [15:0] port_e_pullup_enable;
  logic [15:0] pin_in;
  logic [15:0] next_pullup;
  logic [31:0] next_rdata;
  logic bus_drive;
  logic wb_req;
  logic wb_wr;

  //////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  assign wb_req = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master sees ack, never earlier.
  assign wb_wr = wb_req && wb_we_i && wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req && !wb_ack_o;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `APM_OFS_CLK_SEL: next_rdata[2:0] = clk_sel;
      `APM_OFS_BUS_CTRL: next_rdata[`APM_BUS_KEEP_BIT] = bus_keep_driven_bit;
      `APM_OFS_PORT_FUNC: next_rdata[15:0] = port_func;
      `APM_OFS_PORT_DIR: next_rdata[15:0] = port_dir;
      `APM_OFS_PORT_OUT: next_rdata[15:0] = port_out;
      `APM_OFS_PA_PULLUP: next_rdata[15:0] = port_a_pullup_enable;
      `APM_OFS_PE_PULLUP: next_rdata[15:0] = port_e_pullup_enable;
      `APM_OFS_PIN_IN: next_rdata[15:0] = pin_in;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_ack_o)
      wb_dat_o <= next_rdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_sel <= apm_clk_sel_t'(`APM_RST_CLK_SEL);
    else if (wb_wr && wb_adr_i == `APM_OFS_CLK_SEL && wb_sel_i[0])
      clk_sel <= apm_clk_sel_t'(wb_dat_i[2:0]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_keep_driven_bit <= `APM_RST_BUS_CTRL;
    else if (wb_wr && wb_adr_i == `APM_OFS_BUS_CTRL && wb_sel_i[0])
      bus_keep_driven_bit <= wb_dat_i[`APM_BUS_KEEP_BIT];
  end

  // Each 16-bit register is written per byte lane.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[15:8] = dat[15:8];
    return res;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_func <= `APM_RST_PORT_FUNC;
    else if (wb_wr && wb_adr_i == `APM_OFS_PORT_FUNC)
      port_func <= merge16(port_func, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_dir <= `APM_RST_PORT_DIR;
    else if (wb_wr && wb_adr_i == `APM_OFS_PORT_DIR)
      port_dir <= merge16(port_dir, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_out <= `APM_RST_PORT_OUT;
    else if (wb_wr && wb_adr_i == `APM_OFS_PORT_OUT)
      port_out <= merge16(port_out, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_a_pullup_enable <= `APM_RST_PULLUP;
    else if (wb_wr && wb_adr_i == `APM_OFS_PA_PULLUP)
      port_a_pullup_enable <= merge16(port_a_pullup_enable, wb_dat_i,
                                      wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_e_pullup_enable <= `APM_RST_PULLUP;
    else if (wb_wr && wb_adr_i == `APM_OFS_PE_PULLUP)
      port_e_pullup_enable <= merge16(port_e_pullup_enable, wb_dat_i,
                                      wb_sel_i);
  end

  // Pins are taken as synchronous, so one stage suffices for readback.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_in <= 16'h0000;
    else
      pin_in <= addr_pin_i;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  // Floating an idle bus saves nothing useful and lets lines drift.
  assign bus_drive = emi_bus_active_i || bus_keep_driven_bit;

  genvar n;
  generate
    for (n = 0; n < 16; n++)
    begin : g_line
      if (n < `APM_GRP0_END)
      begin : g_pa_hi
        assign next_pullup[n] =
          port_a_pullup_enable[n + `APM_GRP0_PA_BASE];
      end
      else if (n < `APM_GRP1_END)
      begin : g_pe
        assign next_pullup[n] =
          port_e_pullup_enable[n - `APM_GRP0_END + `APM_GRP1_PE_BASE];
      end
      else
      begin : g_pa_lo
        assign next_pullup[n] =
          port_a_pullup_enable[n - `APM_GRP1_END + `APM_GRP2_PA_BASE];
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          addr_pin_o[n] <= 1'b0;
          addr_pin_oe_o[n] <= 1'b0;
          addr_pin_pullup_o[n] <= 1'b1;
        end
        else
        begin
          addr_pin_o[n] <= port_func[n] ? port_out[n] : emi_addr_i[n];
          addr_pin_oe_o[n] <= port_func[n] ? port_dir[n] : bus_drive;
          addr_pin_pullup_o[n] <= next_pullup[n];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      emi_ctrl_o <= 2'h0;
      emi_ctrl_oe_o <= 1'b0;
    end
    else
    begin
      emi_ctrl_o <= emi_ctrl_i;
      emi_ctrl_oe_o <= bus_drive;
    end
  end

  apm_clk_out u_clk_out
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(clk_sel),
    .src_i({test_clock_i, postscaler_clock_i, prescaler_clock_i,
            osc_clock_i, peripheral_bus_clock_i, master_system_clock_i,
            1'b0}),
    .clk_out_o(buffered_clock_out_pin_o),
    .clk_out_oe_o(buffered_clock_out_pin_oe_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_rst_held;
    rst_i ##1 rst_i;
  endsequence

  AST_RST_PINS: assert property (@(posedge clk_i)
    s_rst_held |-> addr_pin_oe_o == 16'h0000 && !emi_ctrl_oe_o &&
      addr_pin_pullup_o == 16'hFFFF && !buffered_clock_out_pin_oe_o)
    else $error("Drivers on or pull-ups off during reset.");

  AST_RST_FUNC: assert property (@(posedge clk_i)
    rst_i |=> port_func == 16'h0000)
    else $error("Pins not in address function after reset.");

  AST_ADDR_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> ((addr_pin_o ^ $past(emi_addr_i)) & ~$past(port_func))
      == 16'h0000)
    else $error("Address pin does not carry the memory address.");

  AST_IDLE_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    !emi_bus_active_i && !bus_keep_driven_bit |=>
      (addr_pin_oe_o & ~$past(port_func)) == 16'h0000 && !emi_ctrl_oe_o)
    else $error("Idle bus not floated.");

  AST_KEEP_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_keep_driven_bit ##1 bus_keep_driven_bit |->
      (addr_pin_oe_o | $past(port_func)) == 16'hFFFF && emi_ctrl_oe_o)
    else $error("Kept-driven bus not driven.");

  AST_PORT_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> ((addr_pin_oe_o ^ $past(port_dir)) & $past(port_func))
      == 16'h0000)
    else $error("Port pin direction wrong.");

  AST_PULLUP_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> {addr_pin_pullup_o[8], addr_pin_pullup_o[6],
              addr_pin_pullup_o[0]} == $past({port_a_pullup_enable[0],
              port_e_pullup_enable[2], port_a_pullup_enable[8]}))
    else $error("Pull-up bit mapped to wrong pin.");

  AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer not a single cycle.");

endmodule

// ==== verilog/apm_pkg.sv ====
package apm_pkg;

  typedef enum logic [2:0]
  {
    APM_CLK_OFF,
    APM_CLK_MASTER,
    APM_CLK_PERIPH,
    APM_CLK_OSC,
    APM_CLK_PRESCALE,
    APM_CLK_POSTSCALE,
    APM_CLK_TEST0,
    APM_CLK_TEST1
  } apm_clk_sel_t;

  typedef logic [7:0] apm_clk_src_t;

endpackage
